// [logic/wdpc_defs.vh]
// Constants and field layout for the watchdog prescale control block
//
// Contract
// - Interval codes 10011 and above are reserved and fall back to the 1:32 ratio.
// - Code 10010 selects the 1:8388608 ratio, the longest 256 s interval.
// - Code 10001 selects 1:4194304 and code 10000 selects 1:2097152.
// - Each code step doubles the ratio from 1:32 at code 0, so 01000 gives 1:8192.
// - Code 00111 gives 1:4096, half the interval of the next code up.
// - Control bits 7 and 6 always read back as zero.
// - After any reset the interval field comes up at the 1:65536 two-second code.
// - The soft enable bit governs the watchdog only when the config enable field is 01.
// - A time-out in sleep gives no reset but wakes the core and updates the flags.
// - The counter clears on reset, clear instruction, sleep entry and exit, oscillator
//       failure, start-up timer running and while disabled.

`ifndef WDPC_DEFS_VH
`define WDPC_DEFS_VH

// ----------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------
`define WDPC_ADDR_W 3
`define WDPC_DATA_W 8
`define WDPC_OFS_CONTROL 3'h0
`define WDPC_OFS_PWRSTAT 3'h1
`define WDPC_OFS_IRQSTAT 3'h2
`define WDPC_OFS_IRQMASK 3'h3

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define WDPC_CTL_EN_BIT 0
`define WDPC_CTL_SEL_LSB 1
`define WDPC_CTL_SEL_MSB 5
`define WDPC_SEL_W 5
`define WDPC_SEL_RESET 5'h0b
`define WDPC_SEL_LAST 5'h12
`define WDPC_EN_RESET 1'h0
`define WDPC_BASE_SHIFT 5'h05

// ----------------------------------------------------------------
// Power control status fields
// ----------------------------------------------------------------
`define WDPC_PS_TO_BIT 0
`define WDPC_PS_PD_BIT 1
`define WDPC_PS_RST_BIT 2

// ----------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------
`define WDPC_IRQ_W 2
`define WDPC_IRQ_WAKE_BIT 0
`define WDPC_IRQ_RST_BIT 1

// ----------------------------------------------------------------
// Config enable field encodings
// ----------------------------------------------------------------
`define WDPC_CFG_OFF 2'h0
`define WDPC_CFG_SOFT 2'h1
`define WDPC_CFG_NOSLEEP 2'h2
`define WDPC_CFG_ON 2'h3

// ----------------------------------------------------------------
// Counter
// ----------------------------------------------------------------
`define WDPC_CNT_W 23
`define WDPC_CNT_ZERO 23'h000000
`define WDPC_CNT_ONE 23'h000001

`endif

// [logic/wdpc_div.v]
// Watchdog tick counter with programmable terminal count
`timescale 1ns/1ps
`include "wdpc_defs.vh"

module wdpc_div (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Control
    input wire clear_in,
    input wire tick_in,
    input wire [`WDPC_CNT_W-1:0] limit_in,
    // Status
    output reg [`WDPC_CNT_W-1:0] count_out,
    output reg expire_out
);

    // Terminal count reached on this tick
    wire at_limit;
    assign at_limit = (count_out == limit_in);

    // Count ticks, restart on clear or on expiry
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_out <= `WDPC_CNT_ZERO;
            expire_out <= 1'b0;
        end else if (clear_in) begin
            count_out <= `WDPC_CNT_ZERO;
            expire_out <= 1'b0;
        end else if (tick_in && at_limit) begin
            count_out <= `WDPC_CNT_ZERO;
            expire_out <= 1'b1;
        end else begin
            if (tick_in) begin
                count_out <= count_out + `WDPC_CNT_ONE;
            end
            expire_out <= 1'b0;
        end
    end

endmodule

// [logic/wdpc_top.v]
// Watchdog prescale control: register file, enable logic, time-out handling
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "wdpc_defs.vh"

module wdpc_top (
    // Clock and reset
    input wire CLK_SYS_IN,
    input wire RST_IN,
    // Register port
    input wire [`WDPC_ADDR_W-1:0] ADDR_IN,
    input wire [`WDPC_DATA_W-1:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [`WDPC_DATA_W-1:0] RDATA_OUT,
    // Watchdog oscillator pin
    input wire WD_OSC_IN,
    // Core and configuration
    input wire [1:0] WD_CONFIG_EN_IN,
    input wire SLEEP_IN,
    input wire CLEAR_WD_INSTR_IN,
    input wire OSC_FAIL_IN,
    input wire OST_RUN_IN,
    // Watchdog results
    output reg WD_RESET_OUT,
    output reg WAKE_OUT,
    output reg WD_ACTIVE_OUT,
    output reg TIMEOUT_FLAG_N_OUT,
    output reg POWERDOWN_FLAG_N_OUT,
    output reg WD_RESET_FLAG_OUT,
    // Interrupt
    output reg IRQ_OUT
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------

    // Terminal count for an interval code, ratio minus one
    function [`WDPC_CNT_W-1:0] wdpc_limit;
        input [`WDPC_SEL_W-1:0] sel;
        reg [`WDPC_SEL_W-1:0] shift;
        reg [`WDPC_CNT_W:0] ratio;
        begin
            if (sel > `WDPC_SEL_LAST) begin
                shift = `WDPC_BASE_SHIFT;
            end else begin
                shift = sel + `WDPC_BASE_SHIFT;
            end
            // Codes 10010, 10001, 10000, 00111 land on 2^23, 2^22, 2^21, 2^12
            ratio = {{`WDPC_CNT_W{1'b0}}, 1'b1} << shift;
            wdpc_limit = ratio[`WDPC_CNT_W-1:0] - `WDPC_CNT_ONE;
        end
    endfunction

    // Address decode helper for a strobe
    function wdpc_hit;
        input strobe;
        input [`WDPC_ADDR_W-1:0] addr;
        input [`WDPC_ADDR_W-1:0] ofs;
        begin
            wdpc_hit = strobe && (addr == ofs);
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg osc_meta_q;
    reg osc_sync_q;
    reg osc_prev_q;
    reg sleep_prev_q;
    reg [`WDPC_SEL_W-1:0] sel_q;
    reg [`WDPC_SEL_W-1:0] sel_d;
    reg soft_en_q;
    reg soft_en_d;
    reg [`WDPC_IRQ_W-1:0] irq_stat_q;
    reg [`WDPC_IRQ_W-1:0] irq_stat_d;
    reg [`WDPC_IRQ_W-1:0] irq_mask_q;
    reg rst_flag_d;
    reg to_n_d;
    reg pd_n_d;
    reg [`WDPC_DATA_W-1:0] rdata_d;
    reg active_d;

    wire wd_tick;
    wire sleep_change;
    wire counter_clear;
    wire expire;
    wire [`WDPC_CNT_W-1:0] limit;
    wire timeout_sleep;
    wire timeout_awake;
    wire wr_ctl;
    wire wr_pwr;
    wire wr_stat;
    wire wr_mask;

    // ----------------------------------------------------------------
    // Watchdog oscillator crossing
    // ----------------------------------------------------------------

    // Two-stage synchroniser, then an edge register for tick detection
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            osc_meta_q <= WD_OSC_IN;
            osc_sync_q <= osc_meta_q;
            osc_prev_q <= osc_sync_q;
        end
    end

    // One tick per rising edge of the watchdog oscillator
    assign wd_tick = osc_sync_q && !osc_prev_q;

    // ----------------------------------------------------------------
    // Sleep edge tracking
    // ----------------------------------------------------------------

    // Remember previous sleep level to spot entry and exit
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sleep_prev_q <= 1'b0;
        end else begin
            sleep_prev_q <= SLEEP_IN;
        end
    end

    assign sleep_change = SLEEP_IN ^ sleep_prev_q;

    // ----------------------------------------------------------------
    // Enable decision
    // ----------------------------------------------------------------

    // Config field picks the source; soft enable only counts for 01
    always @* begin
        case (WD_CONFIG_EN_IN)
            `WDPC_CFG_ON: active_d = 1'b1;
            `WDPC_CFG_NOSLEEP: active_d = !SLEEP_IN;
            `WDPC_CFG_SOFT: active_d = soft_en_q;
            default: active_d = 1'b0;
        endcase
    end

    // Counter held clear while any clearing condition stands
    assign counter_clear = !active_d || CLEAR_WD_INSTR_IN || sleep_change ||
                           OSC_FAIL_IN || OST_RUN_IN || WD_RESET_OUT;

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    assign limit = wdpc_limit(sel_q);

    wdpc_div u_div (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .clear_in(counter_clear),
        .tick_in(wd_tick),
        .limit_in(limit),
        .count_out(),
        .expire_out(expire)
    );

    // Expiry splits by whether the core sleeps; a same-cycle clear cancels it
    assign timeout_sleep = expire && active_d && SLEEP_IN && !counter_clear;
    assign timeout_awake = expire && active_d && !SLEEP_IN && !counter_clear;

    // ----------------------------------------------------------------
    // Register strobes
    // ----------------------------------------------------------------
    assign wr_ctl = wdpc_hit(WR_IN, ADDR_IN, `WDPC_OFS_CONTROL);
    assign wr_pwr = wdpc_hit(WR_IN, ADDR_IN, `WDPC_OFS_PWRSTAT);
    assign wr_stat = wdpc_hit(WR_IN, ADDR_IN, `WDPC_OFS_IRQSTAT);
    assign wr_mask = wdpc_hit(WR_IN, ADDR_IN, `WDPC_OFS_IRQMASK);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------

    // Watchdog reset reloads the defaults, software write otherwise
    always @* begin
        sel_d = sel_q;
        soft_en_d = soft_en_q;
        if (timeout_awake) begin
            sel_d = `WDPC_SEL_RESET;
            soft_en_d = `WDPC_EN_RESET;
        end else if (wr_ctl) begin
            sel_d = WDATA_IN[`WDPC_CTL_SEL_MSB:`WDPC_CTL_SEL_LSB];
            soft_en_d = WDATA_IN[`WDPC_CTL_EN_BIT];
        end
    end

    // Control state, two-second code after power-on reset
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sel_q <= `WDPC_SEL_RESET;
            soft_en_q <= `WDPC_EN_RESET;
        end else begin
            sel_q <= sel_d;
            soft_en_q <= soft_en_d;
        end
    end

    // ----------------------------------------------------------------
    // Power control status flags
    // ----------------------------------------------------------------

    // Time-out drops the active-low flag; clear instruction and sleep raise it
    always @* begin
        rst_flag_d = WD_RESET_FLAG_OUT;
        to_n_d = TIMEOUT_FLAG_N_OUT;
        pd_n_d = POWERDOWN_FLAG_N_OUT;
        if (wr_pwr && WDATA_IN[`WDPC_PS_RST_BIT]) begin
            rst_flag_d = 1'b0;
        end
        if (timeout_awake) begin
            rst_flag_d = 1'b1;
        end
        if (CLEAR_WD_INSTR_IN) begin
            to_n_d = 1'b1;
            pd_n_d = 1'b1;
        end else if (SLEEP_IN && !sleep_prev_q) begin
            to_n_d = 1'b1;
            pd_n_d = 1'b0;
        end
        if (timeout_sleep || timeout_awake) begin
            to_n_d = 1'b0;
        end
    end

    // Flag registers; power-on sets both active-low flags
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            WD_RESET_FLAG_OUT <= 1'b0;
            TIMEOUT_FLAG_N_OUT <= 1'b1;
            POWERDOWN_FLAG_N_OUT <= 1'b1;
        end else begin
            WD_RESET_FLAG_OUT <= rst_flag_d;
            TIMEOUT_FLAG_N_OUT <= to_n_d;
            POWERDOWN_FLAG_N_OUT <= pd_n_d;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status and mask
    // ----------------------------------------------------------------

    // Write one to clear; a new event in the same cycle wins
    always @* begin
        irq_stat_d = irq_stat_q;
        if (wr_stat) begin
            irq_stat_d = irq_stat_q & ~WDATA_IN[`WDPC_IRQ_W-1:0];
        end
        if (timeout_sleep) begin
            irq_stat_d[`WDPC_IRQ_WAKE_BIT] = 1'b1;
        end
        if (timeout_awake) begin
            irq_stat_d[`WDPC_IRQ_RST_BIT] = 1'b1;
        end
    end

    // Status, mask and the level interrupt
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_stat_q <= {`WDPC_IRQ_W{1'b0}};
            irq_mask_q <= {`WDPC_IRQ_W{1'b0}};
            IRQ_OUT <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_mask) begin
                irq_mask_q <= WDATA_IN[`WDPC_IRQ_W-1:0];
            end
            IRQ_OUT <= |(irq_stat_d & (wr_mask ? WDATA_IN[`WDPC_IRQ_W-1:0] : irq_mask_q));
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Read mux; unimplemented bits and unmapped offsets give zero
    always @* begin
        rdata_d = {`WDPC_DATA_W{1'b0}};
        if (RD_IN) begin
            case (ADDR_IN)
                `WDPC_OFS_CONTROL: begin
                    rdata_d[`WDPC_CTL_SEL_MSB:`WDPC_CTL_SEL_LSB] = sel_q;
                    rdata_d[`WDPC_CTL_EN_BIT] = soft_en_q;
                end
                `WDPC_OFS_PWRSTAT: begin
                    rdata_d[`WDPC_PS_TO_BIT] = TIMEOUT_FLAG_N_OUT;
                    rdata_d[`WDPC_PS_PD_BIT] = POWERDOWN_FLAG_N_OUT;
                    rdata_d[`WDPC_PS_RST_BIT] = WD_RESET_FLAG_OUT;
                end
                `WDPC_OFS_IRQSTAT: begin
                    rdata_d[`WDPC_IRQ_W-1:0] = irq_stat_q;
                end
                `WDPC_OFS_IRQMASK: begin
                    rdata_d[`WDPC_IRQ_W-1:0] = irq_mask_q;
                end
                default: begin
                    rdata_d = {`WDPC_DATA_W{1'b0}};
                end
            endcase
        end
    end

    // Read data register, valid the cycle after the strobe
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= {`WDPC_DATA_W{1'b0}};
        end else begin
            RDATA_OUT <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Result outputs
    // ----------------------------------------------------------------

    // One-cycle reset and wake pulses, plus the running indication
    always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            WD_RESET_OUT <= 1'b0;
            WAKE_OUT <= 1'b0;
            WD_ACTIVE_OUT <= 1'b0;
        end else begin
            WD_RESET_OUT <= timeout_awake;
            WAKE_OUT <= timeout_sleep;
            WD_ACTIVE_OUT <= active_d;
        end
    end

endmodule

// [verif/wdpc_props.sv]
// Assertion checker for the watchdog prescale control block
`timescale 1ns/1ps
`include "wdpc_defs.vh"

module wdpc_props (
    // Clock and reset
    input wire CLK_SYS_IN,
    input wire RST_IN,
    // Register port
    input wire [`WDPC_ADDR_W-1:0] ADDR_IN,
    input wire RD_IN,
    input wire [`WDPC_DATA_W-1:0] RDATA_OUT,
    // Core side
    input wire [1:0] WD_CONFIG_EN_IN,
    input wire SLEEP_IN,
    input wire CLEAR_WD_INSTR_IN,
    // Watchdog results
    input wire WD_RESET_OUT,
    input wire WAKE_OUT,
    input wire WD_ACTIVE_OUT,
    input wire TIMEOUT_FLAG_N_OUT,
    input wire POWERDOWN_FLAG_N_OUT,
    input wire WD_RESET_FLAG_OUT
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    // Reset pulse lasts one cycle
    sequence s_rst_pulse;
        WD_RESET_OUT ##1 !WD_RESET_OUT;
    endsequence
    // Watchdog held off for several cycles
    sequence s_quiet;
        (!WD_ACTIVE_OUT) [*4];
    endsequence
    property p_ctl_read;
        RD_IN && ADDR_IN == `WDPC_OFS_CONTROL |=> RDATA_OUT[7:6] == 2'h0;
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control top bits set");
    property p_rst_pulse;
        $rose(WD_RESET_OUT) |-> s_rst_pulse;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
    property p_rst_flag;
        WD_RESET_OUT |-> WD_RESET_FLAG_OUT && !TIMEOUT_FLAG_N_OUT;
    endproperty
    a_rst_flag: assert property (p_rst_flag) else $error("reset flags wrong");
    property p_wake;
        WAKE_OUT |-> !WD_RESET_OUT && !TIMEOUT_FLAG_N_OUT;
    endproperty
    a_wake: assert property (p_wake) else $error("sleep time-out wrong");
    property p_off;
        WD_CONFIG_EN_IN == `WDPC_CFG_OFF |=> !WD_ACTIVE_OUT;
    endproperty
    a_off: assert property (p_off) else $error("active while off");
    property p_on;
        WD_CONFIG_EN_IN == `WDPC_CFG_ON |=> WD_ACTIVE_OUT;
    endproperty
    a_on: assert property (p_on) else $error("inactive while on");
    property p_quiet;
        s_quiet |=> !WD_RESET_OUT && !WAKE_OUT;
    endproperty
    a_quiet: assert property (p_quiet) else $error("time-out while disabled");
    property p_clr;
        (CLEAR_WD_INSTR_IN && !SLEEP_IN) [*3] |=> TIMEOUT_FLAG_N_OUT && POWERDOWN_FLAG_N_OUT;
    endproperty
    a_clr: assert property (p_clr) else $error("flags not set by clear");
    property p_sleep;
        $rose(SLEEP_IN) && !CLEAR_WD_INSTR_IN |=> !POWERDOWN_FLAG_N_OUT;
    endproperty
    a_sleep: assert property (p_sleep) else $error("power-down flag not low");
endmodule

bind wdpc_top wdpc_props u_wdpc_props (.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN),
    .ADDR_IN(ADDR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .WD_CONFIG_EN_IN(WD_CONFIG_EN_IN), .SLEEP_IN(SLEEP_IN),
    .CLEAR_WD_INSTR_IN(CLEAR_WD_INSTR_IN), .WD_RESET_OUT(WD_RESET_OUT), .WAKE_OUT(WAKE_OUT),
    .WD_ACTIVE_OUT(WD_ACTIVE_OUT), .TIMEOUT_FLAG_N_OUT(TIMEOUT_FLAG_N_OUT),
    .POWERDOWN_FLAG_N_OUT(POWERDOWN_FLAG_N_OUT), .WD_RESET_FLAG_OUT(WD_RESET_FLAG_OUT));

// [verif/wdpc_top_tb.sv]
// Self-checking testbench for the watchdog prescale control block
`timescale 1ns/1ps
`include "wdpc_defs.vh"

module wdpc_top_tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [2:0] addr = 3'h0;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0, rd = 1'b0, osc = 1'b0, slp = 1'b0, clr = 1'b0, ofail = 1'b0, ost = 1'b0;
    reg [1:0] cfg = 2'h1;
    wire [7:0] rdata;
    wire wdrst, wake, active, to_n, pd_n, rflag, irq;
    integer num_errors = 0, n_tests = 0, n_rst = 0, n_wake = 0, i;

    wdpc_top u_wdpc_top (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .WD_OSC_IN(osc), .WD_CONFIG_EN_IN(cfg),
        .SLEEP_IN(slp), .CLEAR_WD_INSTR_IN(clr), .OSC_FAIL_IN(ofail), .OST_RUN_IN(ost),
        .WD_RESET_OUT(wdrst), .WAKE_OUT(wake), .WD_ACTIVE_OUT(active),
        .TIMEOUT_FLAG_N_OUT(to_n), .POWERDOWN_FLAG_N_OUT(pd_n),
        .WD_RESET_FLAG_OUT(rflag), .IRQ_OUT(irq));

    // 200 MHz clock
    always #2.5 clk = ~clk;
    // Pulse counters, sampled mid-cycle
    always @(negedge clk) begin
        if (wdrst === 1'b1) n_rst = n_rst + 1;
        if (wake === 1'b1) n_wake = n_wake + 1;
    end

    task chk(input string name, input [7:0] exp, input [7:0] got);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // Step to mid-cycle so registered outputs have settled
    task mid;
        @(negedge clk);
    endtask
    task wr_reg(input [2:0] a, input [7:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            cyc(1);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [2:0] a, input [7:0] exp, input string name);
        begin
            addr <= a;
            rd <= 1'b1;
            cyc(1);
            rd <= 1'b0;
            @(negedge clk);
            chk(name, exp, rdata);
            cyc(1);
        end
    endtask
    // Oscillator edges, two clocks high and two low
    task tick(input integer n);
        repeat (n) begin
            osc <= 1'b1;
            cyc(2);
            osc <= 1'b0;
            cyc(2);
        end
    endtask
    task clr3;
        begin
            clr <= 1'b1;
            cyc(3);
            clr <= 1'b0;
            cyc(1);
        end
    endtask

    task t_reset;
        begin
            rd_reg(3'h0, 8'h16, "control reset");
            rd_reg(3'h1, 8'h03, "power status reset");
            rd_reg(3'h5, 8'h00, "unmapped");
            $display("reset test done");
        end
    endtask
    task t_regs;
        begin
            wr_reg(3'h0, 8'hff);
            rd_reg(3'h0, 8'h3f, "control top bits");
            wr_reg(3'h0, 8'h16);
            $display("register test done");
        end
    endtask
    task t_modes;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                cfg <= i[2:1];
                wr_reg(3'h0, {7'h0b, i[0]});
                cyc(2);
                mid();
                chk("active", (i >= 4 || i == 3), active);
                cyc(1);
            end
            slp <= 1'b1;
            cfg <= 2'h2;
            cyc(3);
            mid();
            chk("active in sleep", 8'h00, active);
            cyc(1);
            slp <= 1'b0;
            cfg <= 2'h1;
            wr_reg(3'h0, 8'h16);
            clr3();
            $display("mode test done");
        end
    endtask
    task t_expire(input [4:0] code);
        integer r, n0;
        begin
            r = (code > 5'h12) ? 32 : (1 << (code + 5));
            wr_reg(3'h0, {2'b00, code, 1'b1});
            clr3();
            n0 = n_rst;
            tick(r - 1);
            cyc(6);
            chk("early reset", n0, n_rst);
            tick(1);
            cyc(6);
            chk("reset count", n0 + 1, n_rst);
            rd_reg(3'h0, 8'h16, "control reload");
            $display("expiry test done for code %h", code);
        end
    endtask
    task t_irq;
        begin
            rd_reg(3'h1, 8'h06, "power status after");
            wr_reg(3'h1, 8'h04);
            rd_reg(3'h1, 8'h02, "reset flag cleared");
            rd_reg(3'h2, 8'h02, "irq status");
            mid();
            chk("irq masked", 8'h00, irq);
            cyc(1);
            wr_reg(3'h3, 8'h02);
            cyc(2);
            mid();
            chk("irq raised", 8'h01, irq);
            cyc(1);
            wr_reg(3'h2, 8'h02);
            cyc(2);
            mid();
            chk("irq cleared", 8'h00, irq);
            cyc(1);
            rd_reg(3'h2, 8'h00, "irq status cleared");
            $display("interrupt test done");
        end
    endtask
    task t_sleep;
        integer n0, w0;
        begin
            wr_reg(3'h0, 8'h01);
            clr3();
            n0 = n_rst;
            w0 = n_wake;
            slp <= 1'b1;
            cyc(2);
            mid();
            chk("flags in sleep", 8'h02, {to_n, pd_n});
            cyc(1);
            tick(32);
            cyc(6);
            mid();
            chk("wake count", w0 + 1, n_wake);
            chk("no reset in sleep", n0, n_rst);
            chk("timeout flag", 8'h00, to_n);
            cyc(1);
            // Awake time-out bit is still sticky from the expiry tests
            rd_reg(3'h2, 8'h03, "wake status");
            rd_reg(3'h0, 8'h01, "control kept");
            wr_reg(3'h2, 8'h01);
            slp <= 1'b0;
            clr3();
            mid();
            chk("flags after clear", 8'h03, {to_n, pd_n});
            cyc(1);
            $display("sleep test done");
        end
    endtask
    task t_hold;
        integer n0;
        begin
            n0 = n_rst;
            ofail <= 1'b1;
            tick(40);
            ofail <= 1'b0;
            ost <= 1'b1;
            tick(40);
            ost <= 1'b0;
            tick(20);
            clr3();
            tick(20);
            cyc(6);
            chk("held counter", n0, n_rst);
            tick(12);
            cyc(6);
            chk("count after clear", n0 + 1, n_rst);
            tick(40);
            cyc(6);
            chk("soft disabled", n0 + 1, n_rst);
            $display("clearing test done");
        end
    endtask
    // Mid-run reset restores control and flag defaults
    task t_rst2;
        begin
            wr_reg(3'h0, 8'h3f);
            rst <= 1'b1;
            cyc(2);
            rst <= 1'b0;
            rd_reg(3'h0, 8'h16, "control after reset");
            rd_reg(3'h1, 8'h03, "power status after reset");
            $display("second reset test done");
        end
    endtask

    task results;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #450000;
        num_errors = num_errors + 1;
        results();
    end
    // Main sequence
    initial begin
        cyc(20);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_modes();
        t_expire(5'h00);
        t_irq();
        t_expire(5'h01);
        t_expire(5'h07);
        t_expire(5'h08);
        t_expire(5'h13);
        t_expire(5'h1f);
        t_sleep();
        wr_reg(3'h0, 8'h01);
        clr3();
        t_hold();
        t_rst2();
        results();
    end
endmodule
